// ===== hdl/psaod_pkg.sv
// Constants and types shared by the instruction decoder files
package psaod_pkg;

  // ----------------------------------------------------------------
  // Registers, modes and steps
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_STACK_POINTER = 3'h6;
  localparam logic [2:0] REG_PROGRAM_COUNTER = 3'h7;
  localparam logic [2:0] MODE_AUTOINC = 3'h2;
  localparam logic [2:0] MODE_AUTOINC_DEF = 3'h3;
  localparam logic [2:0] MODE_AUTODEC_DEF = 3'h5;
  localparam logic [2:0] MODE_INDEX = 3'h6;
  localparam logic [2:0] MODE_INDEX_DEF = 3'h7;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [1:0] STEP_BYTE = 2'h1;
  localparam logic [1:0] STEP_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [3:0] OPC_ADD = 4'h6;
  localparam logic [3:0] OPC_SUB = 4'he;
  localparam logic [2:0] OPC_MOVE = 3'h1;
  localparam logic [2:0] OPC_COMPARE = 3'h2;
  localparam logic [2:0] OPC_BIT_TEST = 3'h3;
  localparam logic [2:0] OPC_BIT_CLEAR = 3'h4;
  localparam logic [2:0] OPC_BIT_SET = 3'h5;
  localparam logic [3:0] OPC_BRANCH_ZERO = 4'h0;
  localparam logic [7:0] OPC_EMULATOR_TRAP = 8'h88;
  localparam logic [7:0] OPC_TRAP = 8'h89;
  localparam logic [6:0] OPC_DECREMENT_LOOP = 7'h3f;
  localparam logic [9:0] OPC_CALL_SUPERVISOR = 10'h038;
  localparam logic [9:0] OPC_TEST_AND_SET = 10'h03a;
  localparam logic [9:0] OPC_INTERLOCKED_WRITE = 10'h03b;
  localparam logic [12:0] OPC_OPERATE_HIGH = 13'h0000;

  typedef enum logic [4:0] {
    OP_RESERVED = 5'h00,
    OP_ADD = 5'h01,
    OP_SUB = 5'h02,
    OP_BIT_CLEAR = 5'h03,
    OP_BIT_SET = 5'h04,
    OP_MOVE = 5'h05,
    OP_COMPARE = 5'h06,
    OP_BIT_TEST = 5'h07,
    OP_BRANCH = 5'h08,
    OP_EMULATOR_TRAP = 5'h09,
    OP_TRAP = 5'h0a,
    OP_HALT = 5'h0b,
    OP_WAIT_INTERRUPT = 5'h0c,
    OP_INTERRUPT_RETURN = 5'h0d,
    OP_BREAKPOINT_TRAP = 5'h0e,
    OP_IO_TRAP = 5'h0f,
    OP_RESET_BUS = 5'h10,
    OP_ALT_INTERRUPT_RETURN = 5'h11,
    OP_READ_CPU_TYPE = 5'h12,
    OP_TEST_AND_SET = 5'h13,
    OP_INTERLOCKED_WRITE = 5'h14,
    OP_CALL_SUPERVISOR = 5'h15,
    OP_DECREMENT_LOOP = 5'h16
  } psaod_op_t;

  // Code is {instr[15], instr[10:8]}; carry clear doubles as higher-or-same
  typedef enum logic [3:0] {
    COND_NONE = 4'h0,
    COND_UNCONDITIONAL = 4'h1,
    COND_NOT_EQUAL = 4'h2,
    COND_EQUAL = 4'h3,
    COND_GREATER_EQUAL = 4'h4,
    COND_LESS_THAN = 4'h5,
    COND_GREATER_THAN = 4'h6,
    COND_LESS_EQUAL = 4'h7,
    COND_PLUS = 4'h8,
    COND_MINUS = 4'h9,
    COND_HIGHER = 4'ha,
    COND_LOWER_SAME = 4'hb,
    COND_OVERFLOW_CLEAR = 4'hc,
    COND_OVERFLOW_SET = 4'hd,
    COND_CARRY_CLEAR = 4'he,
    COND_CARRY_SET = 4'hf
  } psaod_cond_t;

  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_FETCH = 3'h1,
    ST_DECODE = 3'h2,
    ST_EXT = 3'h3,
    ST_INDIRECT = 3'h4,
    ST_DONE = 3'h5
  } psaod_state_t;

  typedef struct packed {
    psaod_op_t op;
    logic byte_op;
    psaod_cond_t cond;
    logic [7:0] low_byte;
    logic [2:0] loop_reg;
    logic [5:0] loop_offset;
    logic [5:0] src_spec;
    logic [5:0] dst_spec;
    logic has_src;
    logic has_dst;
    logic [1:0] src_step;
    logic [1:0] dst_step;
    logic reserved;
  } psaod_dec_t;

  typedef struct packed {
    logic from_counter;
    logic immediate;
    logic [15:0] ea;
    logic [15:0] data;
  } psaod_opnd_t;

  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } psaod_mem_t;

  typedef struct packed {
    psaod_state_t st;
    logic [15:0] program_counter;
    logic [15:0] instr;
    psaod_dec_t dec;
    psaod_opnd_t src;
    psaod_opnd_t dst;
    psaod_mem_t mem;
    logic cur_dst;
    logic dec_valid;
  } psaod_regs_t;

  localparam psaod_regs_t REGS_RESET = '0;

endpackage

// ===== hdl/psaod_spec_eval.sv
// Operand specifier evaluator: program counter modes and step size
`timescale 1ns/1ps
module psaod_spec_eval (
  input wire logic [5:0] spec,
  input wire logic byte_op,
  output logic counter_ext,
  output logic counter_indirect,
  output logic [1:0] step
);

  logic [2:0] mode;
  logic [2:0] regn;
  logic on_counter;

  assign mode = spec[5:3];
  assign regn = spec[2:0];
  assign on_counter = (regn == psaod_pkg::REG_PROGRAM_COUNTER);

  always_comb begin
    counter_ext = on_counter && (mode == psaod_pkg::MODE_AUTOINC || mode == psaod_pkg::MODE_AUTOINC_DEF
                  || mode == psaod_pkg::MODE_INDEX || mode == psaod_pkg::MODE_INDEX_DEF);
    counter_indirect = on_counter && (mode == psaod_pkg::MODE_INDEX_DEF);
    // Stack pointer and counter keep word alignment even for byte data
    if (!byte_op || regn >= psaod_pkg::REG_STACK_POINTER || mode == psaod_pkg::MODE_AUTOINC_DEF
        || mode == psaod_pkg::MODE_AUTODEC_DEF) begin
      step = psaod_pkg::STEP_WORD;
    end else begin
      step = psaod_pkg::STEP_BYTE;
    end
  end

endmodule

// ===== hdl/psaod_decoder.sv
// Instruction decoder with program counter operand resolution
//
// Contract
// - Mode 2 on program counter is autoincrement; operand is the next word.
// - Immediate source: fetch instruction, step counter, read operand, step again.
// - Mode 3 on program counter: following word is the absolute operand address.
// - Mode 6 on program counter: following word plus counter is the address.
// - Mode 7 on program counter: offset plus counter points to the address.
// - Relative modes add the counter value already past the offset word.
// - Stack pointer autoincrement and autodecrement always step by two.
// - Instruction bit 15 set selects byte form for move, compare, bit test, bit clear and bit set; clear selects word form.
// - Add is 06SSDD and subtract is 16SSDD with source and destination.
// - Bit clear B4SSDD and bit set B5SSDD, leading digit chooses byte.
// - Conditional branch codes with the low byte as offset.
// - Unconditional, overflow, carry and higher branch codes; higher-or-same equals carry clear.
// - 104000-104377 emulator trap, 104400-104777 trap; low byte goes to handler.
// - Fixed operate codes 000000 through 000007.
// - Test-and-set 0072DD and interlocked write 0073DD, one destination.
// - Call supervisor 0070DD with one operand specifier.
// - Decrement-and-loop 077RNN, register R and six-bit backward offset.
// - Each word read through the program counter advances it by two.
`timescale 1ns/1ps
module psaod_decoder (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic next_req,
  input wire logic next_load,
  input wire logic [15:0] next_target,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic dec_valid,
  output psaod_pkg::psaod_dec_t dec,
  output psaod_pkg::psaod_opnd_t src_opnd,
  output psaod_pkg::psaod_opnd_t dst_opnd,
  output logic [15:0] program_counter
);

  psaod_pkg::psaod_regs_t s_r;
  psaod_pkg::psaod_regs_t s_nxt;
  psaod_pkg::psaod_dec_t d;
  psaod_pkg::psaod_opnd_t opnd;
  logic [15:0] ins;
  logic [15:0] counter_after;
  logic [5:0] cur_spec;
  logic [2:0] cur_mode;
  logic more_dst;
  logic src_ext;
  logic src_indirect;
  logic [1:0] src_step;
  logic dst_ext;
  logic dst_indirect;
  logic [1:0] dst_step;
  logic [5:0] src_field;
  logic [5:0] dst_field;
  logic byte_form;
  logic cur_indirect;

  assign ins = s_r.instr;
  assign counter_after = s_r.program_counter + psaod_pkg::WORD_STEP;
  assign cur_spec = s_r.cur_dst ? d.dst_spec : d.src_spec;
  assign cur_mode = cur_spec[5:3];

  // ----------------------------------------------------------------
  // Operand specifier evaluation
  // ----------------------------------------------------------------
  // Fields come from the word itself, not from the decode result, so the
  // evaluators never loop back into the process that reads their steps.
  always_comb begin
    src_field = ins[11:6];
    dst_field = ins[5:0];
    byte_form = 1'b0;
    if (ins[14:12] >= psaod_pkg::OPC_MOVE && ins[14:12] <= psaod_pkg::OPC_BIT_SET) begin
      byte_form = ins[15];
    end
  end

  psaod_spec_eval u_src_eval (
    .spec(src_field),
    .byte_op(byte_form),
    .counter_ext(src_ext),
    .counter_indirect(src_indirect),
    .step(src_step)
  );

  psaod_spec_eval u_dst_eval (
    .spec(dst_field),
    .byte_op(byte_form),
    .counter_ext(dst_ext),
    .counter_indirect(dst_indirect),
    .step(dst_step)
  );

  // Destination still needs an extension word after the source is done
  assign more_dst = !s_r.cur_dst && d.has_dst && dst_ext;
  assign cur_indirect = s_r.cur_dst ? dst_indirect : src_indirect;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  always_comb begin
    d = '0;
    d.op = psaod_pkg::OP_RESERVED;
    d.cond = psaod_pkg::COND_NONE;
    d.reserved = 1'b1;
    d.low_byte = ins[7:0];
    d.loop_reg = ins[8:6];
    d.loop_offset = ins[5:0];
    d.src_spec = ins[11:6];
    d.dst_spec = ins[5:0];
    if (ins[15:12] == psaod_pkg::OPC_ADD) begin
      d.op = psaod_pkg::OP_ADD;
      d.has_src = 1'b1;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
    end else if (ins[15:12] == psaod_pkg::OPC_SUB) begin
      d.op = psaod_pkg::OP_SUB;
      d.has_src = 1'b1;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
    end else if (ins[14:12] >= psaod_pkg::OPC_MOVE && ins[14:12] <= psaod_pkg::OPC_BIT_SET) begin
      d.byte_op = ins[15];
      d.has_src = 1'b1;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
      if (ins[14:12] == psaod_pkg::OPC_BIT_CLEAR) begin
        d.op = psaod_pkg::OP_BIT_CLEAR;
      end else if (ins[14:12] == psaod_pkg::OPC_BIT_SET) begin
        d.op = psaod_pkg::OP_BIT_SET;
      end else if (ins[14:12] == psaod_pkg::OPC_BIT_TEST) begin
        d.op = psaod_pkg::OP_BIT_TEST;
      end else if (ins[14:12] == psaod_pkg::OPC_COMPARE) begin
        d.op = psaod_pkg::OP_COMPARE;
      end else begin
        d.op = psaod_pkg::OP_MOVE;
      end
    end else if (ins[14:11] == psaod_pkg::OPC_BRANCH_ZERO && {ins[15], ins[10:8]} != 4'h0) begin
      // Condition comes straight from the code bits, so aliases cannot diverge
      d.op = psaod_pkg::OP_BRANCH;
      d.cond = psaod_pkg::psaod_cond_t'({ins[15], ins[10:8]});
      d.reserved = 1'b0;
    end else if (ins[15:8] == psaod_pkg::OPC_EMULATOR_TRAP) begin
      d.op = psaod_pkg::OP_EMULATOR_TRAP;
      d.reserved = 1'b0;
    end else if (ins[15:8] == psaod_pkg::OPC_TRAP) begin
      d.op = psaod_pkg::OP_TRAP;
      d.reserved = 1'b0;
    end else if (ins[15:9] == psaod_pkg::OPC_DECREMENT_LOOP) begin
      d.op = psaod_pkg::OP_DECREMENT_LOOP;
      d.reserved = 1'b0;
    end else if (ins[15:6] == psaod_pkg::OPC_CALL_SUPERVISOR) begin
      d.op = psaod_pkg::OP_CALL_SUPERVISOR;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
    end else if (ins[15:6] == psaod_pkg::OPC_TEST_AND_SET) begin
      d.op = psaod_pkg::OP_TEST_AND_SET;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
    end else if (ins[15:6] == psaod_pkg::OPC_INTERLOCKED_WRITE) begin
      d.op = psaod_pkg::OP_INTERLOCKED_WRITE;
      d.has_dst = 1'b1;
      d.reserved = 1'b0;
    end else if (ins[15:3] == psaod_pkg::OPC_OPERATE_HIGH) begin
      d.reserved = 1'b0;
      unique case (ins[2:0])
        3'h0: begin
          d.op = psaod_pkg::OP_HALT;
        end
        3'h1: begin
          d.op = psaod_pkg::OP_WAIT_INTERRUPT;
        end
        3'h2: begin
          d.op = psaod_pkg::OP_INTERRUPT_RETURN;
        end
        3'h3: begin
          d.op = psaod_pkg::OP_BREAKPOINT_TRAP;
        end
        3'h4: begin
          d.op = psaod_pkg::OP_IO_TRAP;
        end
        3'h5: begin
          d.op = psaod_pkg::OP_RESET_BUS;
        end
        3'h6: begin
          d.op = psaod_pkg::OP_ALT_INTERRUPT_RETURN;
        end
        3'h7: begin
          d.op = psaod_pkg::OP_READ_CPU_TYPE;
        end
      endcase
    end
    // Absent operands keep a zero step, so no phantom access is implied
    if (d.has_src) begin
      d.src_step = src_step;
    end
    if (d.has_dst) begin
      d.dst_step = dst_step;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every memory request is preceded by a cycle with the request low, so
  // an acknowledge can never be counted twice for one request.
  always_comb begin
    s_nxt = s_r;
    s_nxt.dec_valid = 1'b0;
    opnd = s_r.cur_dst ? s_r.dst : s_r.src;
    unique case (s_r.st)
      psaod_pkg::ST_HOLD: begin
        if (next_req) begin
          if (next_load) begin
            s_nxt.program_counter = next_target;
          end
          s_nxt.st = psaod_pkg::ST_FETCH;
        end
      end
      psaod_pkg::ST_FETCH: begin
        if (!s_r.mem.req) begin
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.addr = s_r.program_counter;
        end else if (mem_ack) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.instr = mem_rdata;
          s_nxt.program_counter = counter_after;
          s_nxt.src = '0;
          s_nxt.dst = '0;
          s_nxt.cur_dst = 1'b0;
          s_nxt.st = psaod_pkg::ST_DECODE;
        end
      end
      psaod_pkg::ST_DECODE: begin
        s_nxt.dec = d;
        // Reserved words skip operand resolution entirely
        if (!d.reserved && d.has_src && src_ext) begin
          s_nxt.cur_dst = 1'b0;
          s_nxt.st = psaod_pkg::ST_EXT;
        end else if (!d.reserved && d.has_dst && dst_ext) begin
          s_nxt.cur_dst = 1'b1;
          s_nxt.st = psaod_pkg::ST_EXT;
        end else begin
          s_nxt.st = psaod_pkg::ST_DONE;
        end
      end
      psaod_pkg::ST_EXT: begin
        if (!s_r.mem.req) begin
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.addr = s_r.program_counter;
        end else if (mem_ack) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.program_counter = counter_after;
          opnd = '0;
          opnd.from_counter = 1'b1;
          if (cur_mode == psaod_pkg::MODE_AUTOINC) begin
            opnd.immediate = 1'b1;
            opnd.ea = s_r.program_counter;
            opnd.data = mem_rdata;
          end else if (cur_mode == psaod_pkg::MODE_AUTOINC_DEF) begin
            opnd.ea = mem_rdata;
          end else begin
            // Offset joins the counter already advanced past this word
            opnd.ea = mem_rdata + counter_after;
          end
          if (s_r.cur_dst) begin
            s_nxt.dst = opnd;
          end else begin
            s_nxt.src = opnd;
          end
          if (cur_indirect) begin
            s_nxt.st = psaod_pkg::ST_INDIRECT;
          end else if (more_dst) begin
            s_nxt.cur_dst = 1'b1;
          end else begin
            s_nxt.st = psaod_pkg::ST_DONE;
          end
        end
      end
      psaod_pkg::ST_INDIRECT: begin
        if (!s_r.mem.req) begin
          s_nxt.mem.req = 1'b1;
          s_nxt.mem.addr = opnd.ea;
        end else if (mem_ack) begin
          s_nxt.mem.req = 1'b0;
          opnd.ea = mem_rdata;
          if (s_r.cur_dst) begin
            s_nxt.dst = opnd;
          end else begin
            s_nxt.src = opnd;
          end
          if (more_dst) begin
            s_nxt.cur_dst = 1'b1;
            s_nxt.st = psaod_pkg::ST_EXT;
          end else begin
            s_nxt.st = psaod_pkg::ST_DONE;
          end
        end
      end
      psaod_pkg::ST_DONE: begin
        s_nxt.dec_valid = 1'b1;
        s_nxt.st = psaod_pkg::ST_HOLD;
      end
      default: begin
        s_nxt = psaod_pkg::REGS_RESET;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= psaod_pkg::REGS_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req = s_r.mem.req;
  assign mem_addr = s_r.mem.addr;
  assign dec_valid = s_r.dec_valid;
  assign dec = s_r.dec;
  assign src_opnd = s_r.src;
  assign dst_opnd = s_r.dst;
  assign program_counter = s_r.program_counter;

endmodule

// ===== dv/psaod_mem_model.sv
// Word memory answering the decoder read port with a variable wait
`timescale 1ns/1ps
module psaod_mem_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] wait_cyc,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  // --------------------
  // Storage and answer
  // --------------------
  logic [15:0] words [0:255];
  logic [1:0] cnt_r;
  // Idle data toggles so a stale word never looks like an answer
  always_ff @(posedge clock) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (sys_rst) begin
      cnt_r <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_req && !mem_ack) begin
      if (cnt_r == 2'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= words[mem_addr[8:1]];
        cnt_r <= wait_cyc;
      end else begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// ===== dv/psaod_assertions.sv
// Assertions on the decoder memory port and decode results
`timescale 1ns/1ps
module psaod_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic next_req,
  input wire logic next_load,
  input wire logic [15:0] next_target,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic dec_valid,
  input wire psaod_pkg::psaod_dec_t dec,
  input wire psaod_pkg::psaod_opnd_t src_opnd,
  input wire psaod_pkg::psaod_opnd_t dst_opnd,
  input wire logic [15:0] program_counter
);
  // --------------------
  // Instruction capture
  // --------------------
  // First answer after a result is always the instruction word
  logic first_r;
  logic [15:0] ins_r;
  logic [15:0] fa_r;
  always_ff @(posedge clock) begin
    if (sys_rst || dec_valid) begin
      first_r <= 1'b1;
    end else if (mem_req && mem_ack) begin
      first_r <= 1'b0;
    end
    if (mem_req && mem_ack && first_r) begin
      ins_r <= mem_rdata;
      fa_r <= mem_addr;
    end
  end
  // --------------------
  // Properties
  // --------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_REQ_STAND: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("request changed before answer");
  AST_REQ_DROP: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request held after answer");
  AST_VALID_PULSE: assert property (dec_valid |=> !dec_valid)
    else $error("result flag longer than one cycle");
  AST_PC_STEP: assert property (mem_req && mem_ack && first_r
    |=> program_counter == $past(mem_addr) + 16'h0002) else $error("counter not stepped past instruction");
  AST_BYTE_SEL: assert property (dec_valid && dec.op inside {psaod_pkg::OP_BIT_CLEAR, psaod_pkg::OP_BIT_SET}
    |-> dec.byte_op == ins_r[15]) else $error("byte select wrong");
  AST_ADD_SUB: assert property (dec_valid && ins_r[14:12] == 3'h6
    |-> dec.op == (ins_r[15] ? psaod_pkg::OP_SUB : psaod_pkg::OP_ADD)) else $error("add or subtract wrong");
  AST_TRAP_LOW: assert property (dec_valid && ins_r[15:9] == 7'h44
    |-> dec.low_byte == ins_r[7:0] && program_counter == fa_r + 16'h0002) else $error("trap low byte wrong");
  AST_SP_STEP: assert property (dec_valid && dec.has_dst && dec.dst_spec inside {6'h16, 6'h26}
    |-> dec.dst_step == 2'h2) else $error("stack step not two");
  AST_RSV: assert property (dec_valid && dec.reserved
    |-> dec.op == psaod_pkg::OP_RESERVED && program_counter == fa_r + 16'h0002) else $error("reserved word acted on");
  AST_LOOP_DEC: assert property (dec_valid && ins_r[15:9] == 7'h3f
    |-> dec.op == psaod_pkg::OP_DECREMENT_LOOP && dec.loop_reg == ins_r[8:6]) else $error("loop decode wrong");
  AST_IMM: assert property (dec_valid && dec.has_src && dec.src_spec == 6'h17
    |-> src_opnd.immediate && src_opnd.ea == fa_r + 16'h0002) else $error("immediate source wrong");
  cover property (dec_valid && dec.reserved);
  cover property (dec_valid && src_opnd.immediate);
  cover property (mem_req && !mem_ack ##1 mem_ack);
  cover property (dec_valid && dec.op == psaod_pkg::OP_BRANCH);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_top;
  logic clock, sys_rst, next_req, next_load, mem_req, mem_ack, dec_valid;
  logic [15:0] next_target, mem_addr, mem_rdata, program_counter, a, x;
  logic [1:0] wait_cyc;
  psaod_pkg::psaod_dec_t dec;
  psaod_pkg::psaod_opnd_t src_opnd, dst_opnd;
  int miscompares, cmp_count, cyc, seed, n;
  logic [15:0] brc [15] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0500, 16'h0600, 16'h0700,
    16'h8000, 16'h8100, 16'h8200, 16'h8300, 16'h8400, 16'h8500, 16'h8600, 16'h8700};
  logic [15:0] fix [19] = '{16'h8800, 16'h88ff, 16'h8900, 16'h89ff, 16'h0e05, 16'h0e17, 16'h0e81,
    16'h0ed1, 16'h7e3f, 16'h7fff, 16'h6042, 16'he042, 16'h4042, 16'hc042, 16'h5042, 16'hd042,
    16'h0a00, 16'hffff, 16'h00a0};

  psaod_decoder psaod_decoder_i (.*);
  psaod_mem_model psaod_mem_model_i (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // --------------------
  // Expectations
  // --------------------
  function automatic psaod_pkg::psaod_op_t eop(logic [15:0] w);
    if (w[14:12] == 3'h6) return w[15] ? psaod_pkg::OP_SUB : psaod_pkg::OP_ADD;
    case (w[14:12])
      3'h1: return psaod_pkg::OP_MOVE;
      3'h2: return psaod_pkg::OP_COMPARE;
      3'h3: return psaod_pkg::OP_BIT_TEST;
      3'h4: return psaod_pkg::OP_BIT_CLEAR;
      3'h5: return psaod_pkg::OP_BIT_SET;
      default: ;
    endcase
    if (w[15:8] == 8'h88) return psaod_pkg::OP_EMULATOR_TRAP;
    if (w[15:8] == 8'h89) return psaod_pkg::OP_TRAP;
    if (w[14:11] == 4'h0 && (w[15] || w[10:8] != 3'h0)) return psaod_pkg::OP_BRANCH;
    if (w[15:3] == 13'h0000) return psaod_pkg::psaod_op_t'(psaod_pkg::OP_HALT + 5'(w[2:0]));
    if (w[15:6] == 10'h038) return psaod_pkg::OP_CALL_SUPERVISOR;
    if (w[15:6] == 10'h03a) return psaod_pkg::OP_TEST_AND_SET;
    if (w[15:6] == 10'h03b) return psaod_pkg::OP_INTERLOCKED_WRITE;
    if (w[15:9] == 7'h3f) return psaod_pkg::OP_DECREMENT_LOOP;
    return psaod_pkg::OP_RESERVED;
  endfunction

  // Bytes consumed by extension words read through the counter
  function automatic logic [15:0] ext(logic [15:0] w);
    psaod_pkg::psaod_op_t o;
    logic two, one;
    o = eop(w);
    two = o inside {[psaod_pkg::OP_ADD:psaod_pkg::OP_BIT_TEST]};
    one = o inside {[psaod_pkg::OP_TEST_AND_SET:psaod_pkg::OP_CALL_SUPERVISOR]};
    return 16'(2 * (two && w[8:6] == 3'h7 && w[10])) + 16'(2 * ((two || one) && w[2:0] == 3'h7 && w[4]));
  endfunction

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task expect_dec(input logic [15:0] w, input logic [15:0] at);
    psaod_pkg::psaod_op_t o;
    logic [13:0] fld;
    o = eop(w);
    fld = {dec.has_src, dec.has_dst, dec.src_spec, dec.dst_spec};
    chk(dec_valid, 1'b1);
    chk(dec.op, o);
    chk(dec.reserved, o == psaod_pkg::OP_RESERVED);
    chk(program_counter, 16'(at + 16'h0002 + ext(w)));
    chk(dec.byte_op, o inside {[psaod_pkg::OP_BIT_CLEAR:psaod_pkg::OP_BIT_TEST]} && w[15]);
    if (o == psaod_pkg::OP_BRANCH) chk({dec.cond, dec.low_byte}, {w[15], w[10:8], w[7:0]});
    if (o inside {psaod_pkg::OP_EMULATOR_TRAP, psaod_pkg::OP_TRAP}) chk(dec.low_byte, w[7:0]);
    if (o == psaod_pkg::OP_DECREMENT_LOOP) chk({dec.loop_reg, dec.loop_offset}, w[8:0]);
    if (o inside {[psaod_pkg::OP_ADD:psaod_pkg::OP_BIT_TEST]}) chk(fld, {2'h3, w[11:0]});
    if (o inside {[psaod_pkg::OP_TEST_AND_SET:psaod_pkg::OP_CALL_SUPERVISOR]})
      chk(fld, {2'h1, w[11:0]});
  endtask

  // --------------------
  // Stimulus
  // --------------------
  task put(input logic [15:0] ad, input logic [15:0] v);
    psaod_mem_model_i.words[ad[8:1]] = v;
  endtask

  // Reloads the counter only when the new place differs from it
  task run(input logic [15:0] at, input logic [15:0] i0, input logic [15:0] e1, input logic [15:0] e2);
    put(at, i0);
    put(at + 16'h0002, e1);
    put(at + 16'h0004, e2);
    @(posedge clock);
    next_req <= 1'b1;
    next_load <= (at != program_counter);
    next_target <= at;
    wait_cyc <= 2'($random(seed));
    @(posedge clock);
    next_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (dec_valid !== 1'b1 && n < 60);
    expect_dec(i0, at);
  endtask

  initial begin
    seed = 32'h1e63;
    sys_rst = 1'b1;
    next_req = 1'b0;
    next_load = 1'b0;
    next_target = 16'h0000;
    wait_cyc = 2'h0;
    for (int i = 0; i < 256; i++) put(16'(2 * i), 16'($random(seed)));
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk({mem_req, dec_valid, program_counter}, 18'h0_0000);
    foreach (brc[i]) run(16'h0100, brc[i] | 16'($random(seed) & 255), 16'h0000, 16'h0000);
    for (int i = 0; i < 8; i++) run(16'h0200, 16'(i), 16'h0000, 16'h0000);
    foreach (fix[i]) run(16'h0300, fix[i], 16'h0040, 16'h0000);
    run(16'h0300, 16'h0e17, 16'h0040, 16'h0000);
    chk(dst_opnd, {2'h3, 16'h0302, 16'h0040});
    a = 16'h0100;
    x = 16'h0040;
    put(16'h0146, 16'h1234);
    run(a, 16'h65ff, x, x);
    chk(src_opnd, {2'h3, a + 16'h0002, x});
    chk({dst_opnd.from_counter, dst_opnd.ea}, {1'b1, 16'h1234});
    run(a, 16'h67f7, 16'h0ab0, x);
    chk({src_opnd.from_counter, src_opnd.immediate, src_opnd.ea}, {2'h2, 16'h0ab0});
    chk({dst_opnd.from_counter, dst_opnd.ea}, {1'b1, 16'h0146});
    run(a, 16'hd5a6, 16'h0000, 16'h0000);
    chk({dec.src_step, dec.dst_step}, 4'ha);
    run(a, 16'hd564, 16'h0000, 16'h0000);
    chk({dec.src_step, dec.dst_step}, 4'h5);
    repeat (80) begin
      a = ($random(seed) & 1) ? program_counter : 16'($random(seed)) & 16'hfffe;
      run(a, 16'($random(seed)), 16'($random(seed)), 16'($random(seed)));
    end
    // Reset between runs must return the counter, request and result flag to zero
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk({mem_req, dec_valid, program_counter}, 18'h0_0000);
    run(16'h0100, 16'h6042, 16'h0000, 16'h0000);
    give_verdict();
  end
endmodule

bind psaod_decoder psaod_chk psaod_chk_i (.*);
